// >>> common/sub_pkg.sv
// Package: address map, field layout and reset values of the upper banks
package sub_pkg;

  // ----------------------------------------------------------------
  // Register offsets within the data-memory space
  // ----------------------------------------------------------------
  localparam logic [8:0] ADDR_INDIRECT_B2    = 9'h100;
  localparam logic [8:0] ADDR_TIMER_ZERO     = 9'h101;
  localparam logic [8:0] ADDR_PC_LOW_B2      = 9'h102;
  localparam logic [8:0] ADDR_FLAGS_B2       = 9'h103;
  localparam logic [8:0] ADDR_POINTER_B2     = 9'h104;
  localparam logic [8:0] ADDR_PORT_B_LATCH   = 9'h106;
  localparam logic [8:0] ADDR_PC_HIGH_B2     = 9'h10A;
  localparam logic [8:0] ADDR_INTR_CTRL_B2   = 9'h10B;
  localparam logic [8:0] ADDR_NVM_DATA_LOW   = 9'h10C;
  localparam logic [8:0] ADDR_NVM_ADDR_LOW   = 9'h10D;
  localparam logic [8:0] ADDR_NVM_DATA_HIGH  = 9'h10E;
  localparam logic [8:0] ADDR_NVM_ADDR_HIGH  = 9'h10F;
  localparam logic [8:0] ADDR_INDIRECT_B3    = 9'h180;
  localparam logic [8:0] ADDR_OPTION_CFG     = 9'h181;
  localparam logic [8:0] ADDR_PC_LOW_B3      = 9'h182;
  localparam logic [8:0] ADDR_FLAGS_B3       = 9'h183;
  localparam logic [8:0] ADDR_POINTER_B3     = 9'h184;
  localparam logic [8:0] ADDR_PORT_B_DIR     = 9'h186;
  localparam logic [8:0] ADDR_PC_HIGH_B3     = 9'h18A;
  localparam logic [8:0] ADDR_INTR_CTRL_B3   = 9'h18B;
  localparam logic [8:0] ADDR_NVM_CONTROL    = 9'h18C;
  localparam logic [8:0] ADDR_NVM_UNLOCK     = 9'h18D;

  // Low seven bits of the core registers mirrored in every bank
  localparam logic [6:0] OFS_INDIRECT  = 7'h00;
  localparam logic [6:0] OFS_PC_LOW    = 7'h02;
  localparam logic [6:0] OFS_FLAGS     = 7'h03;
  localparam logic [6:0] OFS_POINTER   = 7'h04;
  localparam logic [6:0] OFS_PC_HIGH   = 7'h0A;
  localparam logic [6:0] OFS_INTR_CTRL = 7'h0B;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int          FLAG_CARRY     = 0;
  localparam int          FLAG_DIGIT     = 1;
  localparam int          FLAG_ZERO      = 2;
  localparam int          FLAG_POWERDOWN = 3;
  localparam int          FLAG_TIMEOUT   = 4;
  localparam logic [7:0]  FLAGS_SW_MASK  = 8'hE7;
  localparam logic [7:0]  FLAGS_ALU_MASK = 8'h07;
  localparam logic [7:0]  FLAGS_BANK_MSK = 8'hE0;
  localparam logic [7:0]  PC_HIGH_MASK   = 8'h1F;
  localparam logic [7:0]  NVM_DATH_MASK  = 8'h3F;
  localparam logic [7:0]  NVM_ADRH_MASK  = 8'h07;
  localparam logic [7:0]  NVM_CTRL_MASK  = 8'h9F;
  localparam logic [7:0]  PORT_A_DIR_MSK = 8'h20;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_ZERO       = 8'h00;
  localparam logic [7:0]  RST_FLAGS      = 8'h18;
  localparam logic [7:0]  RST_OPTION     = 8'hFF;
  localparam logic [7:0]  RST_PORT_B_DIR = 8'hFF;
  localparam logic [7:0]  RST_PORT_A_DIR = 8'hFF;

endpackage : sub_pkg

// >>> logic/sub_bank_map.sv
// Upper-bank special function register decode and storage
//
// Notes on behaviour
// - Core registers answer identically in every bank
// - Unimplemented addresses and bits read zero
// - Upper program counter byte has no address
// - Latch five bits, copy on counter update
// - Port A bit 5 direction always reads one
// - Result-setting writes replace the three ALU flags
// - Timeout and powerdown flags ignore software writes
`timescale 1ns/1ps

module sub_bank_map
  import sub_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic [8:0] addr_i,
  input  wire logic       wr_en_i,
  input  wire logic [7:0] wr_data_i,
  output logic      [7:0] rd_data_o,
  input  wire logic       alu_flags_upd_i,
  input  wire logic [2:0] alu_flags_i,
  input  wire logic [7:0] indirect_rd_i,
  output logic            indirect_wr_o,
  input  wire logic [7:0] timer_zero_rd_i,
  output logic            timer_zero_wr_o,
  input  wire logic [7:0] port_b_pins_i,
  output logic      [7:0] port_b_latch_o,
  output logic      [7:0] port_b_dir_o,
  output logic      [7:0] port_a_dir_o,
  input  wire logic       pc_update_i,
  input  wire logic [7:0] pc_next_low_i,
  input  wire logic       sleep_i,
  input  wire logic       wdt_timeout_i,
  input  wire logic       wdt_clear_i,
  output logic      [4:0] program_counter_hi_o,
  output logic      [7:0] pc_low_byte_o,
  output logic      [7:0] core_flags_o,
  output logic      [7:0] indirect_pointer_o,
  output logic      [7:0] interrupt_control_o,
  output logic      [7:0] option_config_o,
  output logic      [7:0] nvm_data_o,
  output logic      [7:0] nvm_addr_o,
  output logic      [7:0] nvm_control_o,
  output logic            nvm_unlock_wr_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] pc_low;
    logic [4:0] pc_high;
    logic [4:0] pc_upper;
    logic [7:0] flags;
    logic [7:0] pointer;
    logic [7:0] intr_ctrl;
    logic [7:0] option_cfg;
    logic [7:0] port_b_latch;
    logic [7:0] port_b_dir;
    logic [7:0] nvm_data_low;
    logic [7:0] nvm_addr_low;
    logic [7:0] nvm_data_high;
    logic [7:0] nvm_addr_high;
    logic [7:0] nvm_ctrl;
  } sub_state_t;

  sub_state_t state_ff;
  sub_state_t nxt_state;

  // True when the low seven bits hit a bank-mirrored core register
  function automatic logic sub_core_hit(input logic [8:0] a,
                                        input logic [6:0] ofs);
    sub_core_hit = (a[6:0] == ofs);
  endfunction : sub_core_hit

  logic hit_pc_low;
  logic hit_flags;
  logic hit_pointer;
  logic hit_pc_high;
  logic hit_intr;
  logic hit_indirect;

  // ----------------------------------------------------------------
  // Bank-independent decode of core registers
  // ----------------------------------------------------------------
  always_comb begin
    hit_indirect = sub_core_hit(addr_i, OFS_INDIRECT);
    hit_pc_low   = sub_core_hit(addr_i, OFS_PC_LOW);
    hit_flags    = sub_core_hit(addr_i, OFS_FLAGS);
    hit_pointer  = sub_core_hit(addr_i, OFS_POINTER);
    hit_pc_high  = sub_core_hit(addr_i, OFS_PC_HIGH);
    hit_intr     = sub_core_hit(addr_i, OFS_INTR_CTRL);
  end

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  always_comb begin
    if (hit_indirect) begin
      rd_data_o = indirect_rd_i;
    end else if (hit_pc_low) begin
      rd_data_o = state_ff.pc_low;
    end else if (hit_flags) begin
      rd_data_o = state_ff.flags;
    end else if (hit_pointer) begin
      rd_data_o = state_ff.pointer;
    end else if (hit_pc_high) begin
      rd_data_o = {3'h0, state_ff.pc_high};
    end else if (hit_intr) begin
      rd_data_o = state_ff.intr_ctrl;
    end else if (addr_i == ADDR_TIMER_ZERO) begin
      rd_data_o = timer_zero_rd_i;
    end else if (addr_i == ADDR_PORT_B_LATCH) begin
      rd_data_o = port_b_pins_i;
    end else if (addr_i == ADDR_NVM_DATA_LOW) begin
      rd_data_o = state_ff.nvm_data_low;
    end else if (addr_i == ADDR_NVM_ADDR_LOW) begin
      rd_data_o = state_ff.nvm_addr_low;
    end else if (addr_i == ADDR_NVM_DATA_HIGH) begin
      rd_data_o = state_ff.nvm_data_high & NVM_DATH_MASK;
    end else if (addr_i == ADDR_NVM_ADDR_HIGH) begin
      rd_data_o = state_ff.nvm_addr_high & NVM_ADRH_MASK;
    end else if (addr_i == ADDR_OPTION_CFG) begin
      rd_data_o = state_ff.option_cfg;
    end else if (addr_i == ADDR_PORT_B_DIR) begin
      rd_data_o = state_ff.port_b_dir;
    end else if (addr_i == ADDR_NVM_CONTROL) begin
      rd_data_o = state_ff.nvm_ctrl & NVM_CTRL_MASK;
    end else begin
      rd_data_o = 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Write strobes to logic outside this block
  // ----------------------------------------------------------------
  always_comb begin
    indirect_wr_o   = wr_en_i && hit_indirect;
    timer_zero_wr_o = wr_en_i && (addr_i == ADDR_TIMER_ZERO);
    nvm_unlock_wr_o = wr_en_i && (addr_i == ADDR_NVM_UNLOCK);
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    // Program counter update moves the latch into the upper byte
    if (pc_update_i) begin
      nxt_state.pc_low   = pc_next_low_i;
      nxt_state.pc_upper = state_ff.pc_high;
    end
    if (wr_en_i) begin
      if (hit_pc_low) begin
        nxt_state.pc_low   = wr_data_i;
        nxt_state.pc_upper = state_ff.pc_high;
      end else if (hit_flags) begin
        // Software reaches only bank select and, unless masked, ALU bits
        if (alu_flags_upd_i) begin
          nxt_state.flags = (state_ff.flags & ~FLAGS_BANK_MSK)
                          | (wr_data_i & FLAGS_BANK_MSK);
        end else begin
          nxt_state.flags = (state_ff.flags & ~FLAGS_SW_MASK)
                          | (wr_data_i & FLAGS_SW_MASK);
        end
      end else if (hit_pointer) begin
        nxt_state.pointer = wr_data_i;
      end else if (hit_pc_high) begin
        nxt_state.pc_high = wr_data_i[4:0];
      end else if (hit_intr) begin
        nxt_state.intr_ctrl = wr_data_i;
      end else if (addr_i == ADDR_PORT_B_LATCH) begin
        nxt_state.port_b_latch = wr_data_i;
      end else if (addr_i == ADDR_NVM_DATA_LOW) begin
        nxt_state.nvm_data_low = wr_data_i;
      end else if (addr_i == ADDR_NVM_ADDR_LOW) begin
        nxt_state.nvm_addr_low = wr_data_i;
      end else if (addr_i == ADDR_NVM_DATA_HIGH) begin
        nxt_state.nvm_data_high = wr_data_i & NVM_DATH_MASK;
      end else if (addr_i == ADDR_NVM_ADDR_HIGH) begin
        nxt_state.nvm_addr_high = wr_data_i & NVM_ADRH_MASK;
      end else if (addr_i == ADDR_OPTION_CFG) begin
        nxt_state.option_cfg = wr_data_i;
      end else if (addr_i == ADDR_PORT_B_DIR) begin
        nxt_state.port_b_dir = wr_data_i;
      end else if (addr_i == ADDR_NVM_CONTROL) begin
        nxt_state.nvm_ctrl = wr_data_i & NVM_CTRL_MASK;
      end
    end
    // ALU result sets the three arithmetic flags
    if (alu_flags_upd_i) begin
      nxt_state.flags[2:0] = alu_flags_i;
    end
    // Timeout and powerdown follow sleep and watchdog events only
    if (wdt_clear_i) begin
      nxt_state.flags[FLAG_TIMEOUT]   = 1'b1;
      nxt_state.flags[FLAG_POWERDOWN] = 1'b1;
    end else if (sleep_i) begin
      nxt_state.flags[FLAG_TIMEOUT]   = 1'b1;
      nxt_state.flags[FLAG_POWERDOWN] = 1'b0;
    end else if (wdt_timeout_i) begin
      nxt_state.flags[FLAG_TIMEOUT]   = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_ff               <= '0;
      state_ff.flags         <= RST_FLAGS;
      state_ff.option_cfg    <= RST_OPTION;
      state_ff.port_b_dir    <= RST_PORT_B_DIR;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    program_counter_hi_o = state_ff.pc_upper;
    pc_low_byte_o        = state_ff.pc_low;
    core_flags_o         = state_ff.flags;
    indirect_pointer_o   = state_ff.pointer;
    interrupt_control_o  = state_ff.intr_ctrl;
    option_config_o      = state_ff.option_cfg;
    port_b_latch_o       = state_ff.port_b_latch;
    port_b_dir_o         = state_ff.port_b_dir;
    port_a_dir_o         = RST_PORT_A_DIR | PORT_A_DIR_MSK;
    nvm_data_o           = state_ff.nvm_data_low;
    nvm_addr_o           = state_ff.nvm_addr_low;
    nvm_control_o        = state_ff.nvm_ctrl;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_latch_write;
    wr_en_i && hit_pc_high;
  endsequence

  sequence s_pc_update;
    pc_update_i && !(wr_en_i && hit_pc_low);
  endsequence

  property p_mirror_read;
    @(posedge clock_i) disable iff (rst_i)
    (addr_i[6:0] == OFS_PC_HIGH) |-> rd_data_o == {3'h0, state_ff.pc_high};
  endproperty
  a_mirror_read: assert property (p_mirror_read)
    else $error("mirrored latch read differs by bank");

  property p_unmapped_zero;
    @(posedge clock_i) disable iff (rst_i)
    (addr_i == 9'h105 || addr_i == 9'h1FF) |-> rd_data_o == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped address read nonzero");

  property p_latch_upper_zero;
    @(posedge clock_i) disable iff (rst_i)
    hit_pc_high |-> rd_data_o[7:5] == 3'h0;
  endproperty
  a_latch_upper_zero: assert property (p_latch_upper_zero)
    else $error("latch upper bits read nonzero");

  property p_upper_hidden;
    @(posedge clock_i) disable iff (rst_i)
    (wr_en_i && !pc_update_i && !hit_pc_low) |=>
      program_counter_hi_o == $past(program_counter_hi_o);
  endproperty
  a_upper_hidden: assert property (p_upper_hidden)
    else $error("upper counter changed by register write");

  property p_latch_copy;
    @(posedge clock_i) disable iff (rst_i)
    s_latch_write ##1 s_pc_update |=>
      program_counter_hi_o == $past(wr_data_i[4:0], 2);
  endproperty
  a_latch_copy: assert property (p_latch_copy)
    else $error("latch not copied into upper counter");

  property p_port_a5_one;
    @(posedge clock_i) disable iff (rst_i)
    1'b1 |-> port_a_dir_o[5] == 1'b1;
  endproperty
  a_port_a5_one: assert property (p_port_a5_one)
    else $error("port A bit 5 direction not one");

  property p_alu_wins;
    @(posedge clock_i) disable iff (rst_i)
    (alu_flags_upd_i && wr_en_i && hit_flags) |=>
      core_flags_o[2:0] == $past(alu_flags_i);
  endproperty
  a_alu_wins: assert property (p_alu_wins)
    else $error("flags write not suppressed by result");

  property p_to_pd_ro;
    @(posedge clock_i) disable iff (rst_i)
    (!sleep_i && !wdt_timeout_i && !wdt_clear_i) |=>
      core_flags_o[4:3] == $past(core_flags_o[4:3]);
  endproperty
  a_to_pd_ro: assert property (p_to_pd_ro)
    else $error("timeout or powerdown changed without event");

  property p_reset_vals;
    @(posedge clock_i)
    rst_i |=> (core_flags_o[4:3] == 2'b11) && option_config_o == RST_OPTION
              && port_b_dir_o == RST_PORT_B_DIR && pc_low_byte_o == 8'h00;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("reset value wrong");

  sequence s_low_write;
    wr_en_i && hit_pc_low;
  endsequence

  // A low-byte write is a counter update and takes the latch along
  property p_low_write_copy;
    @(posedge clock_i) disable iff (rst_i)
    s_low_write |=> program_counter_hi_o == $past(state_ff.pc_high);
  endproperty
  a_low_write_copy: assert property (p_low_write_copy)
    else $error("low-byte write did not copy latch");

  // A write into a hole must leave every stored bit alone
  property p_hole_ignored;
    @(posedge clock_i) disable iff (rst_i)
    (wr_en_i && (addr_i == 9'h105 || addr_i == 9'h185) && !pc_update_i
     && !alu_flags_upd_i && !sleep_i && !wdt_timeout_i && !wdt_clear_i)
      |=> state_ff == $past(state_ff);
  endproperty
  a_hole_ignored: assert property (p_hole_ignored)
    else $error("write to unmapped address changed state");

  property p_sleep_flags;
    @(posedge clock_i) disable iff (rst_i)
    (sleep_i && !wdt_clear_i) |=> core_flags_o[4:3] == 2'b10;
  endproperty
  a_sleep_flags: assert property (p_sleep_flags)
    else $error("sleep did not set timeout and clear powerdown");

endmodule : sub_bank_map

// >>> tb/sub_core_model.sv
// Far-side model: memory cell behind the pointer and a free-running timer
`timescale 1ns/1ps

module sub_core_model #(
  parameter logic [7:0] PIN_LEVELS = 8'hC3
) (
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       ind_wr_i,
  input  wire logic       tmr_wr_i,
  input  wire logic [7:0] wr_data_i,
  output logic      [7:0] ind_rd_o,
  output logic      [7:0] tmr_rd_o,
  output logic      [7:0] pins_o
);
  // Cell takes indirect writes; the timer counts unless it is loaded
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      ind_rd_o <= 8'h00;
      tmr_rd_o <= 8'h00;
    end else begin
      if (ind_wr_i) begin
        ind_rd_o <= wr_data_i;
      end
      tmr_rd_o <= tmr_wr_i ? wr_data_i : tmr_rd_o + 8'h01;
    end
  end

  // Pins of port B sit at a fixed pattern
  assign pins_o = PIN_LEVELS;
endmodule : sub_core_model

// >>> tb/sub_bank_map_bench.sv
// Self-checking bench for the upper-bank register decode
`timescale 1ns/1ps
`define CHK(N, G, E) begin checks_done++; if ((G) !== (E)) begin \
  bad_count++; $display("CHECK FAILED %s exp %0h got %0h", N, E, G); end end

module sub_bank_map_bench;
  import sub_pkg::*;
  logic clock_i = 1'b0, rst_i = 1'b1, wr_en_i = 1'b0, alu_upd = 1'b0;
  logic pc_update_i = 1'b0, sleep_i = 1'b0, wdt_to = 1'b0, wdt_clr = 1'b0;
  logic [8:0] addr_i = 9'h000;
  logic [7:0] wr_data_i = 8'h00, pc_next_low_i = 8'h00;
  logic [2:0] alu_flags_i = 3'h0;
  logic [7:0] ind_rd, tmr_rd, pins, rd_data_o, port_a_dir_o, pc_low_byte_o;
  logic       ind_wr, tmr_wr;
  logic [4:0] program_counter_hi_o;
  logic [7:0] pb_latch, pb_dir, flags_out, ptr_out, intr_out, opt_out;
  logic [7:0] nvm_d, nvm_a, nvm_c;
  logic       nvm_unl;
  localparam logic [7:0] PINS = 8'hC3;
  int         bad_count = 0;
  int         checks_done = 0;
  localparam logic [8:0] BASES [4] = '{9'h000, 9'h080, 9'h100, 9'h180};
  localparam logic [6:0] OFFS [4] = '{OFS_INDIRECT, OFS_POINTER,
                                      OFS_PC_HIGH, OFS_INTR_CTRL};
  localparam logic [7:0] MASKS [4] = '{8'hFF, 8'hFF, PC_HIGH_MASK, 8'hFF};
  localparam logic [8:0] HOLES [8] = '{9'h105, 9'h107, 9'h108, 9'h109,
                                       9'h185, 9'h187, 9'h189, 9'h18D};

  // ------------------------------------------------------------
  // Clock, design and far-side model
  // ------------------------------------------------------------
  always #25 clock_i = ~clock_i;

  sub_bank_map i_sub_bank_map (.clock_i(clock_i), .rst_i(rst_i),
    .addr_i(addr_i), .wr_en_i(wr_en_i), .wr_data_i(wr_data_i),
    .rd_data_o(rd_data_o), .alu_flags_upd_i(alu_upd),
    .alu_flags_i(alu_flags_i), .indirect_rd_i(ind_rd),
    .indirect_wr_o(ind_wr), .timer_zero_rd_i(tmr_rd),
    .timer_zero_wr_o(tmr_wr), .port_b_pins_i(pins),
    .port_b_latch_o(pb_latch), .port_b_dir_o(pb_dir),
    .port_a_dir_o(port_a_dir_o),
    .pc_update_i(pc_update_i), .pc_next_low_i(pc_next_low_i),
    .sleep_i(sleep_i), .wdt_timeout_i(wdt_to), .wdt_clear_i(wdt_clr),
    .program_counter_hi_o(program_counter_hi_o),
    .pc_low_byte_o(pc_low_byte_o), .core_flags_o(flags_out),
    .indirect_pointer_o(ptr_out), .interrupt_control_o(intr_out),
    .option_config_o(opt_out), .nvm_data_o(nvm_d), .nvm_addr_o(nvm_a),
    .nvm_control_o(nvm_c), .nvm_unlock_wr_o(nvm_unl));

  sub_core_model #(.PIN_LEVELS(PINS)) i_sub_core_model (.clock_i(clock_i),
    .rst_i(rst_i),
    .ind_wr_i(ind_wr), .tmr_wr_i(tmr_wr), .wr_data_i(wr_data_i),
    .ind_rd_o(ind_rd), .tmr_rd_o(tmr_rd), .pins_o(pins));

  // ------------------------------------------------------------
  // Bus tasks: one write lasts one cycle, reads are combinational
  // ------------------------------------------------------------
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(negedge clock_i);
    addr_i = a;
    wr_data_i = d;
    wr_en_i = 1'b1;
    @(negedge clock_i);
    wr_en_i = 1'b0;
  endtask : wr

  task automatic rd(input logic [8:0] a, input logic [7:0] e, input string n);
    @(negedge clock_i);
    addr_i = a;
    #1;
    `CHK(n, rd_data_o, e)
  endtask : rd

  task automatic pulse(ref logic s);
    @(negedge clock_i);
    s = 1'b1;
    @(negedge clock_i);
    s = 1'b0;
  endtask : pulse

  task automatic do_reset;
    @(negedge clock_i);
    rst_i = 1'b1;
    repeat (5) @(negedge clock_i);
    rst_i = 1'b0;
  endtask : do_reset

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic reset_values;
    rd(ADDR_FLAGS_B2, RST_FLAGS, "flags");
    rd(ADDR_OPTION_CFG, RST_OPTION, "option");
    rd(ADDR_PORT_B_DIR, RST_PORT_B_DIR, "port b dir");
    rd(ADDR_PC_HIGH_B3, RST_ZERO, "pc high latch");
    `CHK("pc high", program_counter_hi_o, 5'h00)
    `CHK("port a bit5 dir", port_a_dir_o[5], 1'b1)
  endtask : reset_values

  // Write indirect, pointer, PC high latch and interrupt control from each bank, read from all four
  task automatic mirrors;
    logic [7:0] d;
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 4; i++) begin
        d = 8'h3C + 8'(i * 17 + k * 5);
        wr(BASES[i] | {2'b00, OFFS[k]}, d);
        for (int j = 0; j < 4; j++) begin
          rd(BASES[j] | {2'b00, OFFS[k]}, d & MASKS[k], "mirror");
        end
      end
    end
  endtask : mirrors

  // Holes read zero after writes; partial registers drop missing bits
  task automatic unimplemented;
    for (int i = 0; i < 8; i++) begin
      wr(HOLES[i], 8'hFF);
      rd(HOLES[i], 8'h00, "hole");
    end
    wr(ADDR_NVM_DATA_HIGH, 8'hFF);
    rd(ADDR_NVM_DATA_HIGH, NVM_DATH_MASK, "nvm data hi");
    wr(ADDR_NVM_ADDR_HIGH, 8'hFF);
    rd(ADDR_NVM_ADDR_HIGH, NVM_ADRH_MASK, "nvm addr hi");
  endtask : unimplemented

  // Peripheral registers reach their outputs; strobes follow writes
  task automatic side_regs;
    wr(ADDR_PORT_B_LATCH, 8'h5A);
    `CHK("port b latch", pb_latch, 8'h5A)
    rd(ADDR_PORT_B_LATCH, PINS, "port b pins");
    wr(ADDR_PORT_B_DIR, 8'h0F);
    `CHK("port b dir", pb_dir, 8'h0F)
    wr(ADDR_OPTION_CFG, 8'h42);
    `CHK("option", opt_out, 8'h42)
    wr(ADDR_NVM_DATA_LOW, 8'hA5);
    `CHK("nvm data", nvm_d, 8'hA5)
    wr(ADDR_NVM_ADDR_LOW, 8'h3C);
    `CHK("nvm addr", nvm_a, 8'h3C)
    wr(ADDR_NVM_CONTROL, 8'hFF);
    `CHK("nvm control", nvm_c, NVM_CTRL_MASK)
    rd(ADDR_NVM_CONTROL, NVM_CTRL_MASK, "nvm control rd");
    wr(ADDR_POINTER_B3, 8'h91);
    `CHK("pointer out", ptr_out, 8'h91)
    wr(ADDR_INTR_CTRL_B2, 8'h6E);
    `CHK("intr out", intr_out, 8'h6E)
    // Timer loads on the write edge and counts once before the read
    wr(ADDR_TIMER_ZERO, 8'h80);
    rd(ADDR_TIMER_ZERO, 8'h81, "timer");
    @(negedge clock_i);
    addr_i = ADDR_NVM_UNLOCK;
    wr_en_i = 1'b1;
    #1;
    `CHK("unlock strobe", nvm_unl, 1'b1)
    `CHK("timer strobe", tmr_wr, 1'b0)
    @(negedge clock_i);
    wr_en_i = 1'b0;
    rd(ADDR_NVM_UNLOCK, 8'h00, "unlock rd");
  endtask : side_regs

  // Latch reaches the counter only on an update or a low-byte write
  task automatic pc_latch;
    @(negedge clock_i);
    addr_i = ADDR_PC_HIGH_B2;
    wr_data_i = 8'hFF;
    wr_en_i = 1'b1;
    // Update follows the latch write at once, so the copy sees it
    @(negedge clock_i);
    wr_en_i = 1'b0;
    pc_update_i = 1'b1;
    pc_next_low_i = 8'h34;
    #1;
    `CHK("latch bits", rd_data_o, 8'h1F)
    `CHK("pc high direct", program_counter_hi_o, 5'h00)
    @(negedge clock_i);
    pc_update_i = 1'b0;
    `CHK("pc high upd", program_counter_hi_o, 5'h1F)
    `CHK("pc low upd", pc_low_byte_o, 8'h34)
    wr(ADDR_PC_HIGH_B3, 8'h0A);
    wr(ADDR_PC_LOW_B3, 8'h77);
    `CHK("pc high copy", program_counter_hi_o, 5'h0A)
    rd(ADDR_PC_LOW_B2, 8'h77, "pc low mirror");
  endtask : pc_latch

  // ALU result wins over a write; timeout and powerdown follow events only
  task automatic flags;
    @(negedge clock_i);
    addr_i = ADDR_FLAGS_B3;
    wr_data_i = 8'hFF;
    wr_en_i = 1'b1;
    alu_upd = 1'b1;
    alu_flags_i = 3'b101;
    @(negedge clock_i);
    wr_en_i = 1'b0;
    alu_upd = 1'b0;
    `CHK("flags out", flags_out, 8'hFD)
    rd(ADDR_FLAGS_B3, 8'hFD, "flags alu");
    wr(ADDR_FLAGS_B2, 8'h02);
    rd(ADDR_FLAGS_B2, 8'h1A, "flags sw");
    pulse(sleep_i);
    rd(ADDR_FLAGS_B2, 8'h12, "flags sleep");
    pulse(wdt_to);
    rd(ADDR_FLAGS_B2, 8'h02, "flags timeout");
    pulse(wdt_clr);
    rd(ADDR_FLAGS_B2, 8'h1A, "flags clear");
  endtask : flags

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  // Bounded run time
  initial begin
    repeat (20000) @(posedge clock_i);
    bad_count++;
    end_of_test();
  end

  // Main sequence, with a second reset in mid-run
  initial begin
    do_reset();
    reset_values();
    mirrors();
    unimplemented();
    side_regs();
    pc_latch();
    flags();
    do_reset();
    reset_values();
    end_of_test();
  end
endmodule : sub_bank_map_bench
